// File: ispc_flash_control.sv
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps

module ispc_flash_control
   import ispc_pkg::*;
#(
   parameter int PIN_COUNT = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Register port
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   output logic [7:0] sfr_rdata,
   // CPU side
   input wire logic idle_request,
   input wire logic cpu_addr16,
   input wire logic hw_reboot_pin,
   output logic cpu_hold,
   output logic cpu_resume,
   output logic idle_enter,
   output logic fetch_from_loader,
   output logic device_reset_req,
   // Flash arrays
   input wire logic flash_done,
   input wire logic [7:0] flash_rdata,
   output ispc_flash_req_type flash_req,
   // Port 1 bank line
   output logic [PIN_COUNT-1:0] bank_line_out,
   output logic [PIN_COUNT-1:0] bank_line_oe_n
);

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic program_mode_enable_reg;
   logic loader_boot_select_reg;
   logic upper_bank_enable_reg;
   logic [2:0] bank_line_pin_select_reg;
   logic [7:0] prog_addr_low_reg;
   logic [7:0] prog_addr_high_reg;
   logic [7:0] prog_data_buffer_reg;
   logic [7:0] prog_operation_mode_reg;
   logic hw_reboot_sync;
   ispc_state_type state_reg;
   ispc_state_type state_next;
   logic [7:0] read_mux;
   logic op_legal;
   logic op_is_read;
   logic wr_ctrl;
   logic start_op;

   // The strap comes from a pin, so it passes two flops first.
   ispc_sync #(
      .WIDTH(1)
   ) u_reboot_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .async_in(hw_reboot_pin),
      .sync_out(hw_reboot_sync)
   );

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------

   // Only the three documented codes reach the array.
   assign op_legal = (prog_operation_mode_reg[ISPC_OP_CODE_MSB:0]
                      == ISPC_OP_READ)
                  || (prog_operation_mode_reg[ISPC_OP_CODE_MSB:0]
                      == ISPC_OP_PROGRAM)
                  || (prog_operation_mode_reg[ISPC_OP_CODE_MSB:0]
                      == ISPC_OP_ERASE);
   assign op_is_read = prog_operation_mode_reg[ISPC_OP_CODE_MSB:0]
                       == ISPC_OP_READ;
   assign wr_ctrl = sfr_wr && (sfr_addr == ISPC_PROGRAM_CTRL_ADDR);
   // The idle request becomes an operation only in programming mode.
   assign start_op = idle_request && program_mode_enable_reg
                     && (state_reg == ISPC_ST_IDLE);

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------

   // Mode and boot select bits are plain storage.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         program_mode_enable_reg <= ISPC_PROGRAM_CTRL_RESET[0];
         loader_boot_select_reg <= ISPC_PROGRAM_CTRL_RESET[1];
      end else if (wr_ctrl) begin
         program_mode_enable_reg <=
            sfr_wdata[ISPC_PROGRAM_MODE_ENABLE_BIT];
         loader_boot_select_reg <= sfr_wdata[ISPC_LOADER_BOOT_SELECT_BIT];
      end
   end

   // The trigger bit is never stored: it fires one reset pulse, its position
   // reads back the synchronized reboot strap, and the system reset that follows
   // clears the boot select, which restarts from application flash unless the reboot strap is set.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         device_reset_req <= 1'b0;
      end else begin
         device_reset_req <= wr_ctrl
            && sfr_wdata[ISPC_DEVICE_RESET_TRIGGER_BIT];
      end
   end

   // Fetch source follows boot select, or the reboot strap.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fetch_from_loader <= 1'b0;
      end else begin
         fetch_from_loader <= loader_boot_select_reg
                              || hw_reboot_sync;
      end
   end

   // ----------------------------------------------------------------
   // Banking and programming registers
   // ----------------------------------------------------------------

   // Software writes; the data buffer also takes read results.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         upper_bank_enable_reg <=
            ISPC_ROM_BANK_CTRL_RESET[ISPC_UPPER_BANK_ENABLE_BIT];
         bank_line_pin_select_reg <=
            ISPC_ROM_BANK_CTRL_RESET[ISPC_PIN_SELECT_MSB:0];
         prog_addr_low_reg <= ISPC_PROG_ADDR_RESET;
         prog_addr_high_reg <= ISPC_PROG_ADDR_RESET;
         prog_operation_mode_reg <= ISPC_OPERATION_MODE_RESET;
      end else if (sfr_wr) begin
         if (sfr_addr == ISPC_ROM_BANK_CTRL_ADDR) begin
            upper_bank_enable_reg <= sfr_wdata[ISPC_UPPER_BANK_ENABLE_BIT];
            bank_line_pin_select_reg <= sfr_wdata[ISPC_PIN_SELECT_MSB:0];
         end
         if (sfr_addr == ISPC_PROG_ADDR_LOW_ADDR) begin
            prog_addr_low_reg <= sfr_wdata;
         end
         if (sfr_addr == ISPC_PROG_ADDR_HIGH_ADDR) begin
            prog_addr_high_reg <= sfr_wdata;
         end
         if (sfr_addr == ISPC_PROG_OPERATION_MODE_ADDR) begin
            prog_operation_mode_reg <= sfr_wdata;
         end
      end
   end

   // Array read data wins over a software write in the same cycle; the
   // CPU is held then, so the clash cannot arise in practice.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prog_data_buffer_reg <= ISPC_PROG_DATA_RESET;
      end else if (state_reg == ISPC_ST_WAIT && flash_done
                   && op_is_read) begin
         prog_data_buffer_reg <= flash_rdata;
      end else if (sfr_wr && sfr_addr == ISPC_PROG_DATA_BUFFER_ADDR) begin
         prog_data_buffer_reg <= sfr_wdata;
      end
   end

   // ----------------------------------------------------------------
   // Register read
   // ----------------------------------------------------------------

   // Unused control bits and unmapped addresses read zero.
   always_comb begin
      read_mux = ISPC_UNMAPPED_READ;
      unique case (sfr_addr)
         ISPC_PROGRAM_CTRL_ADDR: begin
            read_mux[ISPC_DEVICE_RESET_TRIGGER_BIT] =
               hw_reboot_sync;
            read_mux[ISPC_LOADER_EXEC_STATUS_BIT] =
               fetch_from_loader;
            read_mux[ISPC_LOADER_BOOT_SELECT_BIT] = loader_boot_select_reg;
            read_mux[ISPC_PROGRAM_MODE_ENABLE_BIT] = program_mode_enable_reg;
         end
         ISPC_ROM_BANK_CTRL_ADDR: begin
            read_mux[ISPC_UPPER_BANK_ENABLE_BIT] = upper_bank_enable_reg;
            read_mux[ISPC_PIN_SELECT_MSB:0] = bank_line_pin_select_reg;
         end
         ISPC_PROG_ADDR_LOW_ADDR: begin
            read_mux = prog_addr_low_reg;
         end
         ISPC_PROG_ADDR_HIGH_ADDR: begin
            read_mux = prog_addr_high_reg;
         end
         ISPC_PROG_DATA_BUFFER_ADDR: begin
            read_mux = prog_data_buffer_reg;
         end
         ISPC_PROG_OPERATION_MODE_ADDR: begin
            read_mux = prog_operation_mode_reg;
         end
         default: begin
            read_mux = ISPC_UNMAPPED_READ;
         end
      endcase
   end

   // Read data stand only in the cycle after the strobe.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sfr_rdata <= ISPC_UNMAPPED_READ;
      end else if (sfr_rd) begin
         sfr_rdata <= read_mux;
      end else begin
         sfr_rdata <= ISPC_UNMAPPED_READ;
      end
   end

   // ----------------------------------------------------------------
   // Operation sequencer
   // ----------------------------------------------------------------

   // An illegal code skips the array and resumes the CPU at once.
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ISPC_ST_IDLE: begin
            if (start_op) begin
               state_next = op_legal ? ISPC_ST_WAIT : ISPC_ST_DONE;
            end
         end
         ISPC_ST_WAIT: begin
            if (flash_done) begin
               state_next = ISPC_ST_DONE;
            end
         end
         ISPC_ST_DONE: begin
            state_next = ISPC_ST_IDLE;
         end
         default: begin
            state_next = ISPC_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_reg <= ISPC_ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // The CPU is held from start until the data buffer is settled.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cpu_hold <= 1'b0;
         cpu_resume <= 1'b0;
         idle_enter <= 1'b0;
      end else begin
         cpu_hold <= (state_next != ISPC_ST_IDLE);
         cpu_resume <= (state_reg == ISPC_ST_DONE);
         idle_enter <= idle_request && !program_mode_enable_reg
                       && (state_reg == ISPC_ST_IDLE);
      end
   end

   // Request to the array is latched at start and held until done.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         flash_req <= '0;
         flash_req.oe_n <= 1'b1;
         flash_req.ce_n <= 1'b1;
      end else if (start_op && op_legal) begin
         flash_req.start <= 1'b1;
         flash_req.loader <=
            prog_operation_mode_reg[ISPC_TARGET_ARRAY_SELECT_BIT];
         flash_req.bank <= prog_operation_mode_reg[ISPC_BANK_BIT];
         flash_req.oe_n <=
            prog_operation_mode_reg[ISPC_OUTPUT_ENABLE_N_BIT];
         flash_req.ce_n <= prog_operation_mode_reg[ISPC_CHIP_ENABLE_N_BIT];
         flash_req.cmd <= prog_operation_mode_reg[ISPC_OP_CODE_MSB:0];
         flash_req.addr <= {prog_addr_high_reg, prog_addr_low_reg};
         flash_req.wdata <= prog_data_buffer_reg;
      end else begin
         flash_req.start <= 1'b0;
         if (state_reg == ISPC_ST_WAIT && flash_done) begin
            flash_req.oe_n <= 1'b1;
            flash_req.ce_n <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Bank line on port 1
   // ----------------------------------------------------------------

   // Only the selected pin is driven, and only with banking enabled.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bank_line_out <= '0;
         bank_line_oe_n <= '1;
      end else begin
         for (int i = 0; i < PIN_COUNT; i++) begin
            bank_line_oe_n[i] <= !(upper_bank_enable_reg
               && bank_line_pin_select_reg == 3'(i));
            bank_line_out[i] <= cpu_addr16 && upper_bank_enable_reg
               && bank_line_pin_select_reg == 3'(i);
         end
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------

   sequence s_trigger_write;
      sfr_wr && sfr_addr == ISPC_PROGRAM_CTRL_ADDR
         && sfr_wdata[ISPC_DEVICE_RESET_TRIGGER_BIT];
   endsequence

   property p_reset_trigger;
      @(posedge clk) disable iff (sys_rst)
      s_trigger_write |=> device_reset_req ##1 !device_reset_req;
   endproperty
   a_reset_trigger: assert property (p_reset_trigger)
      else $error("Reset trigger did not give a one-cycle reset request.");

   property p_reboot_read;
      @(posedge clk) disable iff (sys_rst)
      sfr_rd && sfr_addr == ISPC_PROGRAM_CTRL_ADDR |=>
         sfr_rdata[ISPC_DEVICE_RESET_TRIGGER_BIT] == $past(hw_reboot_sync);
   endproperty
   a_reboot_read: assert property (p_reboot_read)
      else $error("Top control bit does not show reboot mode.");

   property p_loader_status;
      @(posedge clk) disable iff (sys_rst)
      sfr_rd && sfr_addr == ISPC_PROGRAM_CTRL_ADDR |=>
         sfr_rdata[ISPC_LOADER_EXEC_STATUS_BIT] == $past(fetch_from_loader);
   endproperty
   a_loader_status: assert property (p_loader_status)
      else $error("Loader status bit disagrees with fetch source.");

   property p_fetch_route;
      @(posedge clk) disable iff (sys_rst)
      loader_boot_select_reg |=> fetch_from_loader;
   endproperty
   a_fetch_route: assert property (p_fetch_route)
      else $error("Loader boot select did not route fetches.");

   sequence s_op_start;
      idle_request && program_mode_enable_reg && state_reg == ISPC_ST_IDLE
         && op_legal;
   endsequence

   sequence s_op_issued;
      flash_req.start && cpu_hold && !idle_enter;
   endsequence

   property p_idle_starts_op;
      @(posedge clk) disable iff (sys_rst)
      s_op_start |=> s_op_issued;
   endproperty
   a_idle_starts_op: assert property (p_idle_starts_op)
      else $error("Idle request in programming mode did not start work.");

   property p_true_idle;
      @(posedge clk) disable iff (sys_rst)
      idle_request && !program_mode_enable_reg
         && state_reg == ISPC_ST_IDLE |=> idle_enter && !flash_req.start;
   endproperty
   a_true_idle: assert property (p_true_idle)
      else $error("Idle request outside programming mode was not idle.");

   property p_bank_pin;
      @(posedge clk) disable iff (sys_rst)
      upper_bank_enable_reg && $stable(bank_line_pin_select_reg) |=>
         !bank_line_oe_n[$past(bank_line_pin_select_reg)]
         && $countones(~bank_line_oe_n) == 1;
   endproperty
   a_bank_pin: assert property (p_bank_pin)
      else $error("Bank line not driven on exactly the selected pin.");

   property p_address_pair;
      @(posedge clk) disable iff (sys_rst)
      s_op_start |=>
         flash_req.addr == {$past(prog_addr_high_reg),
                            $past(prog_addr_low_reg)};
   endproperty
   a_address_pair: assert property (p_address_pair)
      else $error("Flash address is not the high and low byte pair.");

   property p_read_back;
      @(posedge clk) disable iff (sys_rst)
      state_reg == ISPC_ST_WAIT && flash_done && op_is_read |=>
         prog_data_buffer_reg == $past(flash_rdata)
         ##1 cpu_resume && prog_data_buffer_reg == $past(flash_rdata, 2);
   endproperty
   a_read_back: assert property (p_read_back)
      else $error("Read data not valid in the buffer at resume.");

   property p_array_select;
      @(posedge clk) disable iff (sys_rst)
      s_op_start |=>
         flash_req.bank == $past(prog_operation_mode_reg[ISPC_BANK_BIT])
         && flash_req.loader
            == $past(prog_operation_mode_reg[ISPC_TARGET_ARRAY_SELECT_BIT])
         && flash_req.oe_n
            == $past(prog_operation_mode_reg[ISPC_OUTPUT_ENABLE_N_BIT]);
   endproperty
   a_array_select: assert property (p_array_select)
      else $error("Bank, target or enable not passed to the array.");

   property p_illegal_code;
      @(posedge clk) disable iff (sys_rst)
      start_op && !op_legal |=> !flash_req.start ##1 cpu_resume;
   endproperty
   a_illegal_code: assert property (p_illegal_code)
      else $error("Undefined operation code reached the array.");

endmodule // ispc_flash_control

// File: ispc_pkg.sv
package ispc_pkg;

   // ----------------------------------------------------------------
   // Register offsets on the special-function register port
   // ----------------------------------------------------------------
   localparam logic [7:0] ISPC_PROGRAM_CTRL_ADDR = 8'h9f;
   localparam logic [7:0] ISPC_ROM_BANK_CTRL_ADDR = 8'hab;
   localparam logic [7:0] ISPC_PROG_ADDR_LOW_ADDR = 8'hac;
   localparam logic [7:0] ISPC_PROG_ADDR_HIGH_ADDR = 8'had;
   localparam logic [7:0] ISPC_PROG_DATA_BUFFER_ADDR = 8'hae;
   localparam logic [7:0] ISPC_PROG_OPERATION_MODE_ADDR = 8'haf;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int ISPC_DEVICE_RESET_TRIGGER_BIT = 7;
   localparam int ISPC_LOADER_EXEC_STATUS_BIT = 6;
   localparam int ISPC_LOADER_BOOT_SELECT_BIT = 1;
   localparam int ISPC_PROGRAM_MODE_ENABLE_BIT = 0;
   localparam int ISPC_UPPER_BANK_ENABLE_BIT = 3;
   localparam int ISPC_PIN_SELECT_MSB = 2;
   localparam int ISPC_BANK_BIT = 7;
   localparam int ISPC_TARGET_ARRAY_SELECT_BIT = 6;
   localparam int ISPC_OUTPUT_ENABLE_N_BIT = 5;
   localparam int ISPC_CHIP_ENABLE_N_BIT = 4;
   localparam int ISPC_OP_CODE_MSB = 3;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] ISPC_PROGRAM_CTRL_RESET = 8'h00;
   localparam logic [7:0] ISPC_ROM_BANK_CTRL_RESET = 8'h07;
   localparam logic [7:0] ISPC_PROG_ADDR_RESET = 8'h00;
   localparam logic [7:0] ISPC_PROG_DATA_RESET = 8'h00;
   localparam logic [7:0] ISPC_OPERATION_MODE_RESET = 8'h30;
   localparam logic [7:0] ISPC_UNMAPPED_READ = 8'h00;

   // ----------------------------------------------------------------
   // Operation codes
   // ----------------------------------------------------------------
   localparam logic [3:0] ISPC_OP_READ = 4'h0;
   localparam logic [3:0] ISPC_OP_PROGRAM = 4'h1;
   localparam logic [3:0] ISPC_OP_ERASE = 4'h2;

   // Sequencer states.
   typedef enum logic [1:0] {
      ISPC_ST_IDLE = 2'b00,
      ISPC_ST_WAIT = 2'b01,
      ISPC_ST_DONE = 2'b10
   } ispc_state_type;

   // Everything the flash array needs for one operation.
   typedef struct packed {
      logic start;
      logic loader;
      logic bank;
      logic oe_n;
      logic ce_n;
      logic [3:0] cmd;
      logic [15:0] addr;
      logic [7:0] wdata;
   } ispc_flash_req_type;

endpackage

// File: ispc_sync.sv
`timescale 1ns/10ps

module ispc_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Data
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_reg;

   // Two flops; the first is read only by the second.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule // ispc_sync

// File: ispc_flash_model.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Flash arrays behind the controller
// ----------------------------------------------------------------
module ispc_flash_model
   import ispc_pkg::*;
(
   // Clock
   input wire logic clk,
   // Controller side
   input ispc_flash_req_type flash_req,
   output logic flash_done,
   output logic [7:0] flash_rdata
);
   logic [7:0] mem [logic [17:0]];
   ispc_flash_req_type req;
   int cnt;
   logic [17:0] key;

   // Unused read lines toggle so a stale byte is never mistaken for data.
   initial begin
      flash_done = 1'b0;
      flash_rdata = 8'h00;
      cnt = 0;
   end

   // Each operation ends after a random latency of one to six cycles.
   always @(posedge clk) begin
      key = {req.loader, req.bank & ~req.loader, req.addr};
      flash_done <= 1'b0;
      flash_rdata <= ~flash_rdata;
      if (flash_req.start) begin
         req <= flash_req;
         cnt <= $urandom_range(6, 1);
      end else if (cnt == 1) begin
         cnt <= 0;
         flash_done <= 1'b1;
         if (!req.ce_n && req.oe_n && req.cmd == ISPC_OP_ERASE) begin
            foreach (mem[k]) begin
               if (k[17:16] == key[17:16]) mem[k] = 8'hff;
            end
         end
         // Programming only clears bits, as a real cell does.
         if (!req.ce_n && req.oe_n && req.cmd == ISPC_OP_PROGRAM)
            mem[key] = req.wdata & (mem.exists(key) ? mem[key] : 8'hff);
         if (!req.ce_n && !req.oe_n && req.cmd == ISPC_OP_READ)
            flash_rdata <= mem.exists(key) ? mem[key] : 8'hff;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end
   end
endmodule // ispc_flash_model

// File: isp_flash_control_tb.sv
`timescale 1ns/10ps

module isp_flash_control_tb;
   import ispc_pkg::*;
   logic clk, sys_rst, sfr_wr, sfr_rd, idle_request, cpu_addr16;
   logic hw_reboot_pin, cpu_hold, cpu_resume, idle_enter, fetch_from_loader;
   logic device_reset_req, flash_done, rd_seen, a16;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, flash_rdata, lb, d;
   logic [7:0] bank_line_out, bank_line_oe_n;
   logic [15:0] a;
   ispc_flash_req_type flash_req;
   logic [7:0] exp_q[$];
   int n_mismatch = 0;
   int samples_checked = 0;

   ispc_flash_control i_ispc_flash_control (.clk, .sys_rst, .sfr_addr,
      .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata, .idle_request, .cpu_addr16,
      .hw_reboot_pin, .cpu_hold, .cpu_resume, .idle_enter, .fetch_from_loader,
      .device_reset_req, .flash_done, .flash_rdata, .flash_req,
      .bank_line_out, .bank_line_oe_n);
   ispc_flash_model i_ispc_flash_model (.clk, .flash_req, .flash_done,
      .flash_rdata);

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   always #50 clk = ~clk;

   task automatic chk(string what, logic [7:0] e, logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic wr(logic [7:0] ad, logic [7:0] dt);
      @(posedge clk);
      sfr_addr <= ad;
      sfr_wdata <= dt;
      sfr_wr <= 1'b1;
      @(posedge clk);
      sfr_wr <= 1'b0;
   endtask

   // The expected byte is queued now and compared when it appears.
   task automatic rd(logic [7:0] ad, logic [7:0] e);
      @(posedge clk);
      sfr_addr <= ad;
      sfr_rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk);
      sfr_rd <= 1'b0;
   endtask

   task automatic idle();
      @(posedge clk);
      idle_request <= 1'b1;
      @(posedge clk);
      idle_request <= 1'b0;
      @(negedge clk);
   endtask

   task automatic op(logic [7:0] mode);
      wr(8'haf, mode);
      idle();
      chk("cpu_hold", 8'h01, cpu_hold);
      for (int i = 0; i < 40 && cpu_resume !== 1'b1; i++) @(negedge clk);
      chk("cpu_resume", 8'h01, cpu_resume);
      chk("cpu_hold", 8'h00, cpu_hold);
   endtask

   task automatic end_of_test();
      $display("Compared %0d, mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Read data stand only in the cycle after the strobe.
   always @(posedge clk) rd_seen <= sfr_rd;
   always @(negedge clk) begin
      if (rd_seen) chk("sfr_rdata", exp_q.pop_front(), sfr_rdata);
   end

   // A hang is cut short well past the expected run of some 280 cycles.
   initial begin
      #(4000 * 100);
      n_mismatch++;
      end_of_test();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      {clk, sfr_wr, sfr_rd, idle_request, cpu_addr16, hw_reboot_pin} = '0;
      {sfr_addr, sfr_wdata, rd_seen} = '0;
      sys_rst = 1'b1;
      void'($urandom(83));
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      rd(8'h9f, 8'h00);
      rd(8'hab, 8'h07);
      rd(8'hac, 8'h00);
      rd(8'had, 8'h00);
      rd(8'hae, 8'h00);
      rd(8'haf, 8'h30);
      rd(8'h9e, 8'h00);
      $display("Test register reset values done");
      for (int n = 0; n < 8; n++) begin
         a16 = $urandom;
         cpu_addr16 <= a16;
         wr(8'hab, 8'h08 | n[7:0]);
         repeat (3) @(posedge clk);
         @(negedge clk);
         chk("bank_line_oe_n", ~(8'h01 << n), bank_line_oe_n);
         chk("bank_line_out", {7'h00, a16} << n, bank_line_out);
      end
      wr(8'hab, 8'h07);
      $display("Test bank line done");
      wr(8'h9f, 8'h01);
      for (int t = 0; t < 3; t++) begin
         lb = (t == 0) ? 8'h40 : ((t == 2) ? 8'h80 : 8'h00);
         a = $urandom;
         d = $urandom;
         wr(8'hac, a[7:0]);
         wr(8'had, a[15:8]);
         wr(8'hae, d);
         op(lb | 8'h22);
         op(lb | 8'h00);
         rd(8'hae, 8'hff);
         wr(8'hae, d);
         op(lb | 8'h21);
         op(lb | 8'h00);
         rd(8'hae, d);
      end
      op(8'h33);
      rd(8'hae, d);
      $display("Test flash operations done");
      wr(8'h9f, 8'h00);
      idle();
      chk("idle_enter", 8'h01, idle_enter);
      chk("cpu_hold", 8'h00, cpu_hold);
      wr(8'h9f, 8'h02);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("fetch_from_loader", 8'h01, fetch_from_loader);
      rd(8'h9f, 8'h42);
      wr(8'h9f, 8'h00);
      hw_reboot_pin <= 1'b1;
      repeat (4) @(posedge clk);
      rd(8'h9f, 8'hc0);
      hw_reboot_pin <= 1'b0;
      repeat (4) @(posedge clk);
      $display("Test idle, boot select and strap done");
      wr(8'hae, 8'h5a);
      wr(8'h9f, 8'h83);
      @(negedge clk);
      chk("device_reset_req", 8'h01, device_reset_req);
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      rd(8'hae, 8'h00);
      rd(8'h9f, 8'h00);
      repeat (3) @(posedge clk);
      $display("Test device reset done");
      end_of_test();
   end
endmodule // isp_flash_control_tb
